// *** segregs_pkg.sv ***
// Package for the segment register file and machine control word block.
// Assumes a single 50 MHz clock domain and a plain strobe register port.
package segregs_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] OFF_CODE_SEL = 8'h00;
  localparam logic [7:0] OFF_STACK_SEL = 8'h04;
  localparam logic [7:0] OFF_DATA_SEL = 8'h08;
  localparam logic [7:0] OFF_EXTRA_SEL = 8'h0C;
  localparam logic [7:0] OFF_FOURTH_SEL = 8'h10;
  localparam logic [7:0] OFF_FIFTH_SEL = 8'h14;
  localparam logic [7:0] OFF_CTRL_WORD = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_MASK = 8'h20;
  localparam logic [7:0] OFF_PRIV = 8'h24;
  // Machine control word fields
  localparam int BIT_PAGING = 31;
  localparam int BIT_CACHE_OFF = 30;
  localparam int BIT_NO_WTHRU = 29;
  localparam int BIT_AM = 18;
  localparam int BIT_WP = 16;
  localparam int BIT_NE = 5;
  localparam int BIT_TS = 3;
  localparam int BIT_EM = 2;
  localparam int BIT_MP = 1;
  localparam int BIT_PROTECT = 0;
  localparam logic [31:0] CTRL_DEFINED = 32'hE005_002F;
  localparam logic [31:0] CTRL_RESET = 32'h4000_0000;
  // Real-mode fixed limit and attributes
  localparam logic [31:0] REAL_LIMIT = 32'h0000_FFFF;
  localparam logic [7:0] REAL_ATTR = 8'h93;
  localparam int SEL_SHIFT = 4;
  localparam int NUM_SEGS = 6;
  // Status bits
  localparam int ST_BAD_MODE = 0;
  localparam int ST_BAD_CACHE = 1;
  localparam int ST_PRIV = 2;
  localparam int ST_LIMIT = 3;
  localparam int ST_ATTR = 4;
  // Attribute fields: bit 7 present, bit 3 code, bit 1 writable/readable
  localparam int ATTR_P = 7;
  localparam int ATTR_CODE = 3;
  localparam int ATTR_RW = 1;
  typedef enum logic [1:0] {MODE_REAL, MODE_PROT, MODE_PAGED, MODE_BAD} mode_type;
endpackage

// *** segregs.sv ***
// Segment selectors with hidden descriptor caches and machine control word.
// Assumes synchronous inputs; descriptor fetch is supplied by the core.
// Functional notes
// - six 16-bit selector registers
// - protected segments up to 4 Gbytes
// - real mode segments fixed 64 Kbytes
// - code, stack, four data selectors
// - hidden base, limit, attribute cache each
// - real load sets base to selector<<4
// - protected load refills cache from descriptor
// - reference adds base, checks limit, attributes
// - system registers need privilege level 0
// - control word holds ten defined bits
// - mode decoded from paging and protection
// - paging without protection faults, code 0
// - cache-disable modes stop fills; invalidates stop only with no_write_through
// - both zero allows fills and write-through
// - no_write_through without cache_disable faults
// - cache_disable is one after reset
`timescale 1ns/10ps
module segregs (
  input wire logic CLK_IN, // 50 MHz clock
  input wire logic SRST_IN, // Sync reset, active high
  input wire logic [7:0] ADDR_IN, // Register byte address
  input wire logic [31:0] WDATA_IN, // Write data
  input wire logic WR_IN, // Write strobe
  input wire logic RD_IN, // Read strobe
  output logic [31:0] RDATA_OUT, // Read data, cycle after strobe
  input wire logic [31:0] DESC_BASE_IN, // Descriptor base for protected load
  input wire logic [31:0] DESC_LIMIT_IN, // Descriptor limit
  input wire logic [7:0] DESC_ATTR_IN, // Descriptor attributes
  input wire logic REF_IN, // Memory reference request
  input wire logic [2:0] REF_SEG_IN, // Segment used by reference
  input wire logic [31:0] REF_OFS_IN, // Reference offset
  input wire logic REF_WR_IN, // Reference is a write
  input wire logic REF_EXEC_IN, // Reference is a code fetch
  output logic [31:0] LIN_ADDR_OUT, // Linear address
  output logic LIN_VALID_OUT, // Reference accepted pulse
  output logic REF_FAULT_OUT, // Reference fault pulse
  output logic PROT_FAULT_OUT, // General protection fault pulse
  output logic [15:0] FAULT_CODE_OUT, // Fault error code
  output logic [1:0] MODE_OUT, // Operating mode
  output logic FILL_EN_OUT, // Cache fills allowed
  output logic WTHRU_EN_OUT, // Write-through and invalidates on
  output logic IRQ_OUT // Interrupt level
);
  logic [15:0] sel_r [segregs_pkg::NUM_SEGS];
  logic [31:0] base_r [segregs_pkg::NUM_SEGS];
  logic [31:0] limit_r [segregs_pkg::NUM_SEGS];
  logic [7:0] attr_r [segregs_pkg::NUM_SEGS];
  logic [31:0] ctrl_r;
  logic [1:0] cpl_r;
  logic [4:0] status_r;
  logic [4:0] mask_r;
  logic [4:0] ev_nxt;
  logic [31:0] rdata_nxt;
  logic seg_hit;
  logic [2:0] seg_idx;
  logic sys_hit;
  logic priv_ok;
  logic ctrl_wr;
  logic bad_mode;
  logic bad_cache;
  logic prot;
  segregs_pkg::mode_type mode;
  logic ref_ok;
  logic lim_bad;
  logic attr_bad;

  // Selector address decode; index 0 code, 1 stack, 2..5 data
  always_comb
  begin
    seg_hit = 1'b0;
    seg_idx = 3'h0;
    if (ADDR_IN == segregs_pkg::OFF_CODE_SEL)
    begin
      seg_hit = 1'b1;
      seg_idx = 3'h0;
    end
    else if (ADDR_IN == segregs_pkg::OFF_STACK_SEL)
    begin
      seg_hit = 1'b1;
      seg_idx = 3'h1;
    end
    else if (ADDR_IN == segregs_pkg::OFF_DATA_SEL)
    begin
      seg_hit = 1'b1;
      seg_idx = 3'h2;
    end
    else if (ADDR_IN == segregs_pkg::OFF_EXTRA_SEL)
    begin
      seg_hit = 1'b1;
      seg_idx = 3'h3;
    end
    else if (ADDR_IN == segregs_pkg::OFF_FOURTH_SEL)
    begin
      seg_hit = 1'b1;
      seg_idx = 3'h4;
    end
    else if (ADDR_IN == segregs_pkg::OFF_FIFTH_SEL)
    begin
      seg_hit = 1'b1;
      seg_idx = 3'h5;
    end
  end

  // Control word and mask are system registers, gated by privilege
  assign sys_hit = (ADDR_IN == segregs_pkg::OFF_CTRL_WORD) || (ADDR_IN == segregs_pkg::OFF_MASK);
  assign priv_ok = (cpl_r == 2'h0);
  assign ctrl_wr = WR_IN && (ADDR_IN == segregs_pkg::OFF_CTRL_WORD) && priv_ok;
  assign bad_mode = WDATA_IN[segregs_pkg::BIT_PAGING] &&
    !WDATA_IN[segregs_pkg::BIT_PROTECT];
  assign bad_cache = !WDATA_IN[segregs_pkg::BIT_CACHE_OFF] &&
    WDATA_IN[segregs_pkg::BIT_NO_WTHRU];

  // Mode decode from paging and protection bits
  always_comb
  begin
    case ({ctrl_r[segregs_pkg::BIT_PAGING], ctrl_r[segregs_pkg::BIT_PROTECT]})
      2'b00: mode = segregs_pkg::MODE_REAL;
      2'b01: mode = segregs_pkg::MODE_PROT;
      2'b11: mode = segregs_pkg::MODE_PAGED;
      default: mode = segregs_pkg::MODE_BAD;
    endcase
  end
  assign prot = ctrl_r[segregs_pkg::BIT_PROTECT];

  // Selector and hidden cache update; cache lands with the selector
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      for (int i = 0; i < segregs_pkg::NUM_SEGS; i++)
      begin
        sel_r[i] <= 16'h0000;
        base_r[i] <= 32'h0000_0000;
        limit_r[i] <= segregs_pkg::REAL_LIMIT;
        attr_r[i] <= segregs_pkg::REAL_ATTR;
      end
    end
    else if (WR_IN && seg_hit)
    begin
      sel_r[seg_idx] <= WDATA_IN[15:0];
      if (prot)
      begin
        base_r[seg_idx] <= DESC_BASE_IN;
        limit_r[seg_idx] <= DESC_LIMIT_IN;
        attr_r[seg_idx] <= DESC_ATTR_IN;
      end
      else
      begin
        base_r[seg_idx] <= {12'h000, WDATA_IN[15:0], 4'h0};
        limit_r[seg_idx] <= segregs_pkg::REAL_LIMIT;
        attr_r[seg_idx] <= segregs_pkg::REAL_ATTR;
      end
    end
  end

  // Control word; illegal combinations are rejected whole
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      ctrl_r <= segregs_pkg::CTRL_RESET;
    else if (ctrl_wr && !bad_mode && !bad_cache)
      ctrl_r <= WDATA_IN & segregs_pkg::CTRL_DEFINED;
  end

  // Privilege level is written freely; it models the core's current level
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      cpl_r <= 2'h0;
    else if (WR_IN && ADDR_IN == segregs_pkg::OFF_PRIV)
      cpl_r <= WDATA_IN[1:0];
  end

  // Reference checks against the cached limit and attributes
  assign lim_bad = REF_OFS_IN > limit_r[REF_SEG_IN];
  assign attr_bad = !attr_r[REF_SEG_IN][segregs_pkg::ATTR_P] ||
    (REF_WR_IN && (attr_r[REF_SEG_IN][segregs_pkg::ATTR_CODE] ||
      !attr_r[REF_SEG_IN][segregs_pkg::ATTR_RW])) ||
    (REF_EXEC_IN && !attr_r[REF_SEG_IN][segregs_pkg::ATTR_CODE]);
  assign ref_ok = REF_IN && (REF_SEG_IN < 3'h6) && !lim_bad && !attr_bad;

  // Linear address and reference results, one cycle after request
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      LIN_ADDR_OUT <= 32'h0000_0000;
      LIN_VALID_OUT <= 1'b0;
      REF_FAULT_OUT <= 1'b0;
    end
    else
    begin
      LIN_VALID_OUT <= ref_ok;
      REF_FAULT_OUT <= REF_IN && !ref_ok;
      if (ref_ok)
        LIN_ADDR_OUT <= base_r[REF_SEG_IN] + REF_OFS_IN;
    end
  end

  // Fault pulse for rejected control loads and mask writes; every case uses code 0
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      PROT_FAULT_OUT <= 1'b0;
      FAULT_CODE_OUT <= 16'h0000;
    end
    else
    begin
      PROT_FAULT_OUT <= (ctrl_wr && (bad_mode || bad_cache)) ||
        (WR_IN && sys_hit && !priv_ok);
      FAULT_CODE_OUT <= 16'h0000;
    end
  end

  // Mode and cache-policy outputs
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      MODE_OUT <= 2'h0;
      FILL_EN_OUT <= 1'b0;
      WTHRU_EN_OUT <= 1'b1;
    end
    else
    begin
      MODE_OUT <= mode;
      FILL_EN_OUT <= !ctrl_r[segregs_pkg::BIT_CACHE_OFF];
      WTHRU_EN_OUT <= !ctrl_r[segregs_pkg::BIT_NO_WTHRU];
    end
  end

  // Event collection; a set in the clearing read cycle wins
  always_comb
  begin
    ev_nxt = 5'h00;
    ev_nxt[segregs_pkg::ST_BAD_MODE] = ctrl_wr && bad_mode;
    ev_nxt[segregs_pkg::ST_BAD_CACHE] = ctrl_wr && bad_cache;
    ev_nxt[segregs_pkg::ST_PRIV] = (WR_IN || RD_IN) && sys_hit && !priv_ok;
    ev_nxt[segregs_pkg::ST_LIMIT] = REF_IN && lim_bad;
    ev_nxt[segregs_pkg::ST_ATTR] = REF_IN && attr_bad;
  end

  // Sticky status, cleared by read; mask writable at level 0 only
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      status_r <= 5'h00;
    else if (RD_IN && ADDR_IN == segregs_pkg::OFF_STATUS)
      status_r <= ev_nxt;
    else
      status_r <= status_r | ev_nxt;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      mask_r <= 5'h00;
    else if (WR_IN && ADDR_IN == segregs_pkg::OFF_MASK && priv_ok)
      mask_r <= WDATA_IN[4:0];
  end

  // Interrupt level from the updated status image
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      IRQ_OUT <= 1'b0;
    else if (RD_IN && ADDR_IN == segregs_pkg::OFF_STATUS)
      IRQ_OUT <= |(ev_nxt & mask_r);
    else
      IRQ_OUT <= |((status_r | ev_nxt) & mask_r);
  end

  // Read mux; system registers read zero above level 0, unmapped reads zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (seg_hit)
      rdata_nxt = {16'h0000, sel_r[seg_idx]};
    else if (ADDR_IN == segregs_pkg::OFF_CTRL_WORD && priv_ok)
      rdata_nxt = ctrl_r;
    else if (ADDR_IN == segregs_pkg::OFF_STATUS)
      rdata_nxt = {27'h000_0000, status_r};
    else if (ADDR_IN == segregs_pkg::OFF_MASK && priv_ok)
      rdata_nxt = {27'h000_0000, mask_r};
    else if (ADDR_IN == segregs_pkg::OFF_PRIV)
      rdata_nxt = {30'h0000_0000, cpl_r};
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      RDATA_OUT <= 32'h0000_0000;
    else
      RDATA_OUT <= RD_IN ? rdata_nxt : 32'h0000_0000;
  end

  // Checks
  a_real_base: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (WR_IN && seg_hit && !prot) |=> base_r[$past(seg_idx)] == {12'h000, $past(WDATA_IN[15:0]), 4'h0})
    else $error("real load base wrong");
  a_prot_fill: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (WR_IN && seg_hit && prot) |=> limit_r[$past(seg_idx)] == $past(DESC_LIMIT_IN))
    else $error("protected refill wrong");
  a_mode_reject: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (ctrl_wr && bad_mode) |=> PROT_FAULT_OUT && $stable(ctrl_r))
    else $error("bad mode not rejected");
  a_cache_reject: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (ctrl_wr && bad_cache) |=> PROT_FAULT_OUT && FAULT_CODE_OUT == 16'h0000)
    else $error("bad cache mode not rejected");
  a_never_bad: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    !(ctrl_r[segregs_pkg::BIT_PAGING] && !ctrl_r[segregs_pkg::BIT_PROTECT]))
    else $error("undefined mode held");
  a_priv_gate: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    (WR_IN && ADDR_IN == segregs_pkg::OFF_CTRL_WORD && cpl_r != 2'h0) |=> $stable(ctrl_r))
    else $error("control written above level 0");
  a_lin_addr: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    ref_ok |=> LIN_VALID_OUT && LIN_ADDR_OUT == $past(base_r[REF_SEG_IN] + REF_OFS_IN))
    else $error("linear address wrong");
  a_fill_policy: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    ##1 FILL_EN_OUT == !$past(ctrl_r[segregs_pkg::BIT_CACHE_OFF]))
    else $error("fill policy wrong");
  a_cache_off_reset: assert property (@(posedge CLK_IN)
    $fell(SRST_IN) |-> ctrl_r[segregs_pkg::BIT_CACHE_OFF])
    else $error("cache disable not set after reset");
endmodule

// *** testbench.sv ***
// Self-checking bench for the segment register file and control word.
// Assumes segregs and segregs_pkg are compiled first; one 50 MHz clock.
`timescale 1ns/10ps
module testbench;
  logic clk = 0;
  logic rst = 1;
  logic wr = 0;
  logic rd = 0;
  logic rf = 0;
  logic rw = 0;
  logic rx = 0;
  logic [7:0] ad = 0;
  logic [7:0] da = 0;
  logic [31:0] wd = 0;
  logic [31:0] db = 0;
  logic [31:0] dl = 0;
  logic [31:0] ofs = 0;
  logic [2:0] sg = 0;
  logic [31:0] rdat;
  logic [31:0] lin;
  logic lv, flt, pf, fe, we, irq;
  logic [15:0] gc;
  logic [1:0] md;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 32'h60a6_1954;
  // Reference model: control word, hidden caches, status, mask, level
  logic [31:0] ctl = 32'h4000_0000;
  logic [31:0] bs[6];
  logic [31:0] lm[6];
  logic [7:0] at[6];
  logic [31:0] st = 0;
  logic [31:0] mk = 0;
  logic [1:0] pl = 0;
  logic [31:0] ctab[$];
  logic [15:0] v;
  logic g;

  segregs segregs_inst (.CLK_IN(clk), .SRST_IN(rst), .ADDR_IN(ad), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .DESC_BASE_IN(db), .DESC_LIMIT_IN(dl),
    .DESC_ATTR_IN(da), .REF_IN(rf), .REF_SEG_IN(sg), .REF_OFS_IN(ofs), .REF_WR_IN(rw),
    .REF_EXEC_IN(rx), .LIN_ADDR_OUT(lin), .LIN_VALID_OUT(lv), .REF_FAULT_OUT(flt),
    .PROT_FAULT_OUT(pf), .FAULT_CODE_OUT(gc), .MODE_OUT(md), .FILL_EN_OUT(fe),
    .WTHRU_EN_OUT(we), .IRQ_OUT(irq));

  // Free-running clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  // Watchdog: a hang ends the run as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One write cycle; the fault pulse is watched for two cycles after it
  task automatic wrg(input logic [7:0] a, input logic [31:0] d, output logic f);
    @(posedge clk);
    wr <= 1;
    ad <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    #1 f = pf;
    chk({16'h0000, gc}, 32'h0000_0000);
    @(posedge clk);
    #1 f = f | pf;
  endtask

  // One read cycle; data is looked at only in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1;
    ad <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdat, e);
  endtask

  // Control word load with mode and cache outputs compared to the model
  task automatic wctl(input logic [31:0] d);
    logic f, bm, bc;
    bm = d[31] & !d[0];
    bc = !d[30] & d[29];
    wrg(8'h18, d, f);
    chk(f, bm | bc | (pl != 0));
    if (pl != 0)
      st[2] = 1;
    else if (bm)
      st[0] = 1;
    else if (bc)
      st[1] = 1;
    else
      ctl = d & segregs_pkg::CTRL_DEFINED;
    chk(md, ctl[31] ? 2 : ctl[0]);
    chk(fe, !ctl[30]);
    chk(we, !ctl[29]);
    rdc(8'h18, pl != 0 ? 0 : ctl);
  endtask

  // Selector load followed by a reference at the very next edge, so a
  // late cache refill would show up as a wrong address or verdict
  task automatic ldref(input int s, input logic [15:0] sv, input logic [31:0] o,
    input logic w, input logic x, input logic [31:0] b, input logic [31:0] l,
    input logic [7:0] t);
    logic fl, fa;
    @(posedge clk);
    wr <= 1;
    ad <= 8'(s * 4);
    wd <= {16'h0000, sv};
    db <= b;
    dl <= l;
    da <= t;
    bs[s] = ctl[0] ? b : {12'h000, sv, 4'h0};
    lm[s] = ctl[0] ? l : segregs_pkg::REAL_LIMIT;
    at[s] = ctl[0] ? t : segregs_pkg::REAL_ATTR;
    @(posedge clk);
    wr <= 0;
    rf <= 1;
    sg <= 3'(s);
    ofs <= o;
    rw <= w;
    rx <= x;
    fl = o > lm[s];
    fa = !at[s][7] | (w & (at[s][3] | !at[s][1])) | (x & !at[s][3]);
    @(posedge clk);
    rf <= 0;
    #1 chk(flt, fl | fa);
    chk(lv, !(fl | fa));
    if (!(fl | fa))
      chk(lin, bs[s] + o);
    st[3] = st[3] | fl;
    st[4] = st[4] | fa;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1 chk(fe, 0);
    chk(md, 0);
    chk(irq, 0);
    rdc(8'h18, 32'h4000_0000);
    // Real mode: every selector, offsets at and just past 64 Kbytes
    for (int i = 0; i < 6; i++)
    begin
      v = $random(seed);
      ldref(i, v, 32'h0000_FFFF, 1'($random(seed)), 0, 0, 0, 0);
      ldref(i, v, 32'h0001_0000, 0, 0, 0, 0, 0);
      rdc(8'(i * 4), {16'h0000, v});
    end
    // Every cache combination and every mode but real, illegal ones included
    ctab = '{32'h8000_0000, 32'h2000_0001, 32'h6000_0001, 32'h4000_0001,
      32'hFFFF_FFFF, 32'h0000_0001};
    foreach (ctab[i])
      wctl(ctab[i]);
    // Protected mode: 4 Gbyte segment, limit edge, attribute faults
    v = $random(seed);
    ldref(2, v, 32'hFFFF_FF00, 1, 0, $random(seed), 32'hFFFF_FFFF, 8'h93);
    ldref(3, v, 32'h0000_1234, 0, 0, $random(seed), 32'h0000_1234, 8'h93);
    ldref(3, v, 32'h0000_1235, 0, 0, $random(seed), 32'h0000_1234, 8'h93);
    ldref(0, v, 32'h0000_0010, 0, 1, $random(seed), 32'h0000_FFFF, 8'h9A);
    ldref(0, v, 32'h0000_0010, 1, 0, $random(seed), 32'h0000_FFFF, 8'h9A);
    ldref(5, v, 32'h0000_0010, 0, 1, $random(seed), 32'h0000_FFFF, 8'h93);
    ldref(4, v, 32'h0000_0010, 0, 0, $random(seed), 32'h0000_FFFF, 8'h13);
    // Control word refused away from level 0
    wrg(8'h24, 32'h0000_0003, g);
    pl = 3;
    wctl(32'h0000_0000);
    wrg(8'h24, 32'h0000_0000, g);
    pl = 0;
    // Interrupt: masked, unmasked, then cleared by a status read
    wctl(32'h8000_0001);
    chk(irq, 0);
    wrg(8'h20, 32'h0000_001F, g);
    mk = 32'h0000_001F;
    rdc(8'h20, mk);
    chk(irq, |(st & mk));
    rdc(8'h1C, st);
    st = 0;
    repeat (2) @(posedge clk);
    #1 chk(irq, 0);
    rdc(8'h30, 0);
    conclude();
  end
endmodule
